/* File: rtl/ebr_readout.sv */
// event buffer readout engine: sequential, block, chained and random reads
// assumes: event memory answers a read one clock after mem_rd,
// page p word w lives at {p, w}; acquisition advances ev_wr_page
`timescale 1ns/10ps
module ebr_readout
    import ebr_pkg::*;
#(
    parameter int BS_W = 10,
    parameter int NEV_W = 8
) (
    input wire logic ref_clk,
    input wire logic nrst,
    input wire logic bp_cyc,
    input wire logic bp_req,
    input wire logic [31:0] bp_addr,
    input wire logic [5:0] bp_am,
    input wire logic bp_wr,
    input wire logic bp_dw64,
    output logic bp_ack,
    output logic bp_berr,
    output logic [63:0] bp_data,
    input wire logic lk_cyc,
    input wire logic lk_req,
    input wire logic [31:0] lk_addr,
    input wire logic [5:0] lk_am,
    input wire logic lk_wr,
    input wire logic lk_dw64,
    output logic lk_ack,
    output logic lk_berr,
    output logic [63:0] lk_data,
    input wire logic [31:0] base_addr,
    input wire logic [31:0] chain_base,
    input wire ebr_chain_t chain_pos,
    input wire logic token_in,
    output logic token_out,
    input wire logic [NEV_W-1:0] blt_events,
    input wire logic berr_en,
    input wire logic pad_to_even_word_count,
    input wire logic [BS_W-1:0] block_size,
    input wire logic [11:0] ev_wr_page,
    output logic mem_rd,
    output logic [23:0] mem_addr,
    input wire logic [31:0] mem_data,
    output logic rel_valid,
    output logic [11:0] rel_cnt,
    input wire logic free_wr,
    input wire logic [11:0] free_cnt,
    input wire logic rnd_req,
    input wire logic [11:0] rnd_page,
    input wire logic [11:0] rnd_off,
    input wire logic [9:0] rnd_size,
    output logic rnd_active,
    input wire logic ctrl_bit3,
    input wire logic irq_req,
    output logic lk_irq
);
    ebr_acc_if acc ();

    ebr_arb u_arb (
        .ref_clk(ref_clk),
        .nrst(nrst),
        .bp_cyc(bp_cyc),
        .bp_req(bp_req),
        .bp_addr(bp_addr),
        .bp_am(bp_am),
        .bp_wr(bp_wr),
        .bp_dw64(bp_dw64),
        .bp_ack(bp_ack),
        .bp_berr(bp_berr),
        .bp_data(bp_data),
        .lk_cyc(lk_cyc),
        .lk_req(lk_req),
        .lk_addr(lk_addr),
        .lk_am(lk_am),
        .lk_wr(lk_wr),
        .lk_dw64(lk_dw64),
        .lk_ack(lk_ack),
        .lk_berr(lk_berr),
        .lk_data(lk_data),
        .acc(acc)
    );

    ebr_st_t st_q, st_d;
    logic [11:0] page_q, page_d, rp_q, rp_d, ro_q, ro_d;
    logic [13:0] w_q, w_d, ri_q, ri_d;
    logic [9:0] rs_q, rs_d;
    logic [NEV_W-1:0] nev_q, nev_d;
    logic odd_q, odd_d, half_q, half_d, blk_q, blk_d;
    logic rnd_q, rnd_d, tok_q, tok_d, tout_q, tout_d, tin_q;
    logic ack_q, ack_d, berr_q, berr_d;
    logic [31:0] lo_q, lo_d, hi_q, hi_d;
    logic mrd_d, rel_d, irq_d;
    logic [23:0] maddr_d;
    logic [11:0] relc_d;
    logic [13:0] ev_len, rnd_end, ra;
    logic win_hit, ch_hit, blk, bad, avail, limit, stop;

    assign ev_len = ebr_ev_words(14'(block_size));
    assign rnd_end = 14'(rs_q) + `EBR_HDR_WORDS;
    assign ra = (ri_q < `EBR_HDR_WORDS) ? ri_q : ri_q + 14'(ro_q);
    assign win_hit = acc.addr[31:`EBR_WIN_LSB] ==
        base_addr[31:`EBR_WIN_LSB];
    assign ch_hit = (chain_pos != EBR_CH_OFF) &&
        acc.addr[31:`EBR_WIN_LSB] == chain_base[31:`EBR_WIN_LSB];
    assign blk = ebr_am_blk(acc.am);
    assign bad = !ebr_am_ok(acc.am, acc.dw64) || acc.wr ||
        (acc.from_link && acc.wr && blk);
    assign avail = page_q != ev_wr_page;
    assign limit = blk_q && blt_events != '0 &&
        nev_q >= blt_events;
    assign stop = !avail || limit;
    assign acc.ack = ack_q;
    assign acc.berr = berr_q;
    assign acc.data = {hi_q, lo_q};

    always_comb begin
        st_d = st_q;
        page_d = page_q;
        w_d = w_q;
        ri_d = ri_q;
        rp_d = rp_q;
        ro_d = ro_q;
        rs_d = rs_q;
        rnd_d = rnd_q;
        nev_d = nev_q;
        odd_d = odd_q;
        half_d = half_q;
        blk_d = blk_q;
        tok_d = tok_q;
        tout_d = tout_q;
        ack_d = ack_q;
        berr_d = berr_q;
        lo_d = lo_q;
        hi_d = hi_q;
        mrd_d = 1'b0;
        maddr_d = mem_addr;
        rel_d = 1'b0;
        relc_d = rel_cnt;
        irq_d = ctrl_bit3 && irq_req;
        if (token_in && !tin_q && chain_pos != EBR_CH_OFF && !tout_q) begin
            tok_d = 1'b1;
        end
        if (rnd_req) begin
            rnd_d = 1'b1;
            rp_d = rnd_page;
            ro_d = rnd_off;
            rs_d = rnd_size;
            ri_d = 14'h0;
        end
        if (free_wr) begin
            page_d = page_q + free_cnt;
            w_d = 14'h0;
            rel_d = 1'b1;
            relc_d = free_cnt;
            rnd_d = 1'b0;
        end
        case (st_q)
            EBR_ST_IDLE: begin
                if (!acc.cyc) begin
                    nev_d = '0;
                    odd_d = 1'b0;
                    if (tout_q) begin
                        tout_d = 1'b0;
                        tok_d = chain_pos == EBR_CH_FIRST;
                    end
                end
                if (acc.req && (win_hit || (ch_hit && tok_q))) begin
                    blk_d = blk;
                    half_d = 1'b0;
                    hi_d = `EBR_DUMMY;
                    if (bad || (ch_hit && !blk)) begin
                        berr_d = 1'b1;
                        st_d = EBR_ST_ANS;
                    end else if (rnd_q) begin
                        if (ri_q >= rnd_end) begin
                            berr_d = 1'b1;
                            st_d = EBR_ST_ANS;
                        end else begin
                            mrd_d = 1'b1;
                            maddr_d = {rp_q, ra[11:0]};
                            st_d = EBR_ST_RD;
                        end
                    end else if (stop) begin
                        if (blk_d && pad_to_even_word_count && odd_q) begin
                            lo_d = `EBR_DUMMY;
                            odd_d = 1'b0;
                            ack_d = 1'b1;
                            st_d = EBR_ST_ANS;
                        end else if (ch_hit && chain_pos != EBR_CH_LAST) begin
                            tok_d = 1'b0;
                            tout_d = 1'b1;
                        end else if (ch_hit || (blk_d && berr_en)) begin
                            berr_d = 1'b1;
                            st_d = EBR_ST_ANS;
                            if (ch_hit) begin
                                tok_d = 1'b0;
                            end
                        end else begin
                            lo_d = `EBR_FILLER;
                            ack_d = 1'b1;
                            st_d = EBR_ST_ANS;
                        end
                    end else begin
                        mrd_d = 1'b1;
                        maddr_d = {page_q, w_q[11:0]};
                        st_d = EBR_ST_RD;
                    end
                end
            end
            EBR_ST_RD: begin
                if (half_q) begin
                    hi_d = mem_data;
                end else begin
                    lo_d = mem_data;
                end
                odd_d = !odd_q;
                if (rnd_q) begin
                    if (ri_q == 14'h0) begin
                        lo_d = {`EBR_HDR_TAG, 28'(rnd_end)};
                    end
                    ri_d = ri_q + 14'h1;
                end else if (w_q + 14'h1 >= ev_len) begin
                    w_d = 14'h0;
                    page_d = page_q + 12'h1;
                    rel_d = 1'b1;
                    relc_d = 12'h1;
                    nev_d = nev_q + 1'b1;
                end else begin
                    w_d = w_q + 14'h1;
                end
                if (acc.dw64 && !half_q && !(rnd_q ? ri_d >= rnd_end :
                    (page_d == ev_wr_page || (blk_q && blt_events != '0 &&
                    nev_d >= blt_events)))) begin
                    half_d = 1'b1;
                    mrd_d = 1'b1;
                    maddr_d = rnd_q ? {rp_q, ri_d[11:0] + (ri_d <
                        `EBR_HDR_WORDS ? 12'h0 : ro_q)} :
                        {page_d, w_d[11:0]};
                end else begin
                    if (acc.dw64 && !half_q) begin
                        odd_d = odd_q;
                    end
                    ack_d = 1'b1;
                    st_d = EBR_ST_ANS;
                end
            end
            EBR_ST_ANS: begin
                if (!acc.req) begin
                    ack_d = 1'b0;
                    berr_d = 1'b0;
                    st_d = EBR_ST_IDLE;
                end
            end
            default: st_d = EBR_ST_IDLE;
        endcase
        if (chain_pos == EBR_CH_FIRST && !tout_q && st_q == EBR_ST_IDLE &&
            !acc.cyc && tok_d == tok_q) begin
            tok_d = 1'b1;
        end
        rnd_active = rnd_q;
    end

    always_ff @(posedge ref_clk) begin
        if (!nrst) begin
            st_q <= EBR_ST_IDLE;
            page_q <= 12'h0;
            w_q <= 14'h0;
            ri_q <= 14'h0;
            rp_q <= 12'h0;
            ro_q <= 12'h0;
            rs_q <= 10'h0;
            rnd_q <= 1'b0;
            nev_q <= '0;
            odd_q <= 1'b0;
            half_q <= 1'b0;
            blk_q <= 1'b0;
            tok_q <= 1'b0;
            tout_q <= 1'b0;
            tin_q <= 1'b0;
            ack_q <= 1'b0;
            berr_q <= 1'b0;
            lo_q <= 32'h0;
            hi_q <= 32'h0;
            mem_rd <= 1'b0;
            mem_addr <= 24'h0;
            rel_valid <= 1'b0;
            rel_cnt <= 12'h0;
            token_out <= 1'b0;
            lk_irq <= 1'b0;
        end else begin
            st_q <= st_d;
            page_q <= page_d;
            w_q <= w_d;
            ri_q <= ri_d;
            rp_q <= rp_d;
            ro_q <= ro_d;
            rs_q <= rs_d;
            rnd_q <= rnd_d;
            nev_q <= nev_d;
            odd_q <= odd_d;
            half_q <= half_d;
            blk_q <= blk_d;
            tok_q <= tok_d;
            tout_q <= tout_d;
            tin_q <= token_in;
            ack_q <= ack_d;
            berr_q <= berr_d;
            lo_q <= lo_d;
            hi_q <= hi_d;
            mem_rd <= mrd_d;
            mem_addr <= maddr_d;
            rel_valid <= rel_d;
            rel_cnt <= relc_d;
            token_out <= tout_d;
            lk_irq <= irq_d;
        end
    end
endmodule // ebr_readout

/* File: rtl/ebr_regs.svh */
// event buffer readout: offsets, field positions, codes and counts
// assumes: included by the package and by the bench
`ifndef EBR_REGS_SVH
`define EBR_REGS_SVH

// readout window: 4 kbyte, low address bits not used for sequencing
`define EBR_WIN_LSB 12
`define EBR_HDR_WORDS 14'h0004
// event bytes = 8 * block size + 16
`define EBR_EV_BYTES_PER_BS 14'h0008
`define EBR_EV_XTRA_BYTES 14'h0010
// address modifiers
`define EBR_AM_A32_S 6'h09
`define EBR_AM_A32_BLT 6'h0b
`define EBR_AM_A32_MBLT 6'h08
`define EBR_AM_A24_S 6'h39
`define EBR_AM_A24_BLT 6'h3b
`define EBR_AM_A24_MBLT 6'h38
// answer words with no event behind them
`define EBR_FILLER 32'hffff_ffff
`define EBR_DUMMY 32'h0000_0000
// header marker of a synthesised random readout header
`define EBR_HDR_TAG 4'ha

`endif

/* File: rtl/ebr_pkg.sv */
// event buffer readout: types and shared helpers
// assumes: nothing beyond the constants header
package ebr_pkg;
`include "ebr_regs.svh"

typedef enum logic [1:0] {
    EBR_CH_OFF, EBR_CH_FIRST, EBR_CH_MID, EBR_CH_LAST
} ebr_chain_t;

typedef enum logic [1:0] {EBR_OWN_NONE, EBR_OWN_BP, EBR_OWN_LK} ebr_own_t;

typedef enum logic [1:0] {EBR_ST_IDLE, EBR_ST_RD, EBR_ST_ANS} ebr_st_t;

function automatic logic ebr_am_blk(input logic [5:0] am);
    ebr_am_blk = (am == `EBR_AM_A32_BLT) || (am == `EBR_AM_A24_BLT) ||
        (am == `EBR_AM_A32_MBLT) || (am == `EBR_AM_A24_MBLT);
endfunction

function automatic logic ebr_am_ok(input logic [5:0] am,
    input logic dw64);
    logic m64;
    m64 = (am == `EBR_AM_A32_MBLT) || (am == `EBR_AM_A24_MBLT);
    ebr_am_ok = m64 ? dw64 : (!dw64 && (ebr_am_blk(am) ||
        am == `EBR_AM_A32_S || am == `EBR_AM_A24_S));
endfunction

function automatic logic [13:0] ebr_ev_words(input logic [13:0] bs);
    ebr_ev_words = (bs * `EBR_EV_BYTES_PER_BS + `EBR_EV_XTRA_BYTES) >> 2;
endfunction

endpackage

/* File: rtl/ebr_acc_if.sv */
// arbitrated access between the path arbiter and the readout engine
// assumes: one clock, driven by the arbiter and answered by the engine
`timescale 1ns/10ps
interface ebr_acc_if;
    logic cyc;
    logic req;
    logic [31:0] addr;
    logic [5:0] am;
    logic wr;
    logic dw64;
    logic from_link;
    logic ack;
    logic berr;
    logic [63:0] data;
    modport arb (output cyc, req, addr, am, wr, dw64, from_link,
        input ack, berr, data);
    modport eng (input cyc, req, addr, am, wr, dw64, from_link,
        output ack, berr, data);
endinterface

/* File: rtl/ebr_arb.sv */
// arbiter between backplane and optical link access paths
// assumes: each master holds cyc over its whole cycle, req until answered
`timescale 1ns/10ps
module ebr_arb
    import ebr_pkg::*;
(
    input wire logic ref_clk,
    input wire logic nrst,
    input wire logic bp_cyc,
    input wire logic bp_req,
    input wire logic [31:0] bp_addr,
    input wire logic [5:0] bp_am,
    input wire logic bp_wr,
    input wire logic bp_dw64,
    output logic bp_ack,
    output logic bp_berr,
    output logic [63:0] bp_data,
    input wire logic lk_cyc,
    input wire logic lk_req,
    input wire logic [31:0] lk_addr,
    input wire logic [5:0] lk_am,
    input wire logic lk_wr,
    input wire logic lk_dw64,
    output logic lk_ack,
    output logic lk_berr,
    output logic [63:0] lk_data,
    ebr_acc_if.arb acc
);
    ebr_own_t own_q, own_d;
    logic bp_ack_d, bp_berr_d, lk_ack_d, lk_berr_d;
    logic [63:0] bp_data_d, lk_data_d;
    logic is_lk;

    assign is_lk = (own_q == EBR_OWN_LK);
    assign acc.cyc = is_lk ? lk_cyc : (own_q == EBR_OWN_BP) && bp_cyc;
    assign acc.req = is_lk ? lk_req : (own_q == EBR_OWN_BP) && bp_req;
    assign acc.addr = is_lk ? lk_addr : bp_addr;
    assign acc.am = is_lk ? lk_am : bp_am;
    assign acc.wr = is_lk ? lk_wr : bp_wr;
    assign acc.dw64 = is_lk ? lk_dw64 : bp_dw64;
    assign acc.from_link = is_lk;

    always_comb begin
        own_d = own_q;
        case (own_q)
            EBR_OWN_NONE: begin
                if (bp_cyc) begin
                    own_d = EBR_OWN_BP;
                end else if (lk_cyc) begin
                    own_d = EBR_OWN_LK;
                end
            end
            EBR_OWN_BP: if (!bp_cyc) own_d = EBR_OWN_NONE;
            EBR_OWN_LK: if (!lk_cyc) own_d = EBR_OWN_NONE;
            default: own_d = EBR_OWN_NONE;
        endcase
        bp_ack_d = acc.ack && (own_q == EBR_OWN_BP);
        bp_berr_d = acc.berr && (own_q == EBR_OWN_BP);
        lk_ack_d = acc.ack && is_lk;
        lk_berr_d = acc.berr && is_lk;
        bp_data_d = (own_q == EBR_OWN_BP) ? acc.data : bp_data;
        lk_data_d = is_lk ? acc.data : lk_data;
    end

    always_ff @(posedge ref_clk) begin
        if (!nrst) begin
            own_q <= EBR_OWN_NONE;
            bp_ack <= 1'b0;
            bp_berr <= 1'b0;
            bp_data <= 64'h0;
            lk_ack <= 1'b0;
            lk_berr <= 1'b0;
            lk_data <= 64'h0;
        end else begin
            own_q <= own_d;
            bp_ack <= bp_ack_d;
            bp_berr <= bp_berr_d;
            bp_data <= bp_data_d;
            lk_ack <= lk_ack_d;
            lk_berr <= lk_berr_d;
            lk_data <= lk_data_d;
        end
    end
endmodule // ebr_arb

/* File: verif/ebr_mem_model.sv */
// event memory stand-in for the readout engine
// assumes: data stands while mem_rd stands, taken at the next clock
`timescale 1ns/10ps
module ebr_mem_model (
    input wire logic ref_clk,
    input wire logic mem_rd,
    input wire logic [23:0] mem_addr,
    output logic [31:0] mem_data
);
    logic [31:0] idle_q = 32'h5a5a_5a5a;

    // page p word w holds {c0, p, w}; idle data keeps changing
    always @(posedge ref_clk)
        idle_q <= ~idle_q;

    assign mem_data = (mem_rd === 1'b1) ? {8'hc0, mem_addr} :
        idle_q;
endmodule // ebr_mem_model

/* File: verif/ebr_readout_properties.sv */
// timing checks on the readout engine's answers, release and link irq
// assumes: bound to ebr_readout; one clock, synchronous active-low reset
`timescale 1ns/10ps
module ebr_readout_checker
    import ebr_pkg::*;
(
    input wire logic ref_clk,
    input wire logic nrst,
    input wire logic bp_req,
    input wire logic bp_ack,
    input wire logic bp_berr,
    input wire logic lk_req,
    input wire logic lk_ack,
    input wire logic lk_berr,
    input wire ebr_chain_t chain_pos,
    input wire logic token_out,
    input wire logic rel_valid,
    input wire logic ctrl_bit3,
    input wire logic irq_req,
    input wire logic lk_irq
);
    default clocking cb @(posedge ref_clk);
    endclocking
    default disable iff (!nrst);

    property p_ans_excl;
        !(bp_ack && bp_berr);
    endproperty
    a_ans_excl: assert property (p_ans_excl)
        else $error("ack and bus error together");

    property p_min_lat;
        $rose(bp_req) |-> !(bp_ack || bp_berr) [*2];
    endproperty
    a_min_lat: assert property (p_min_lat)
        else $error("answer too early");

    property p_ans_hold;
        (bp_ack || bp_berr) && bp_req |=> $stable({bp_ack, bp_berr});
    endproperty
    a_ans_hold: assert property (p_ans_hold)
        else $error("answer dropped while request held");

    property p_ans_drop;
        $fell(bp_req) |-> ##[1:3] !(bp_ack || bp_berr);
    endproperty
    a_ans_drop: assert property (p_ans_drop)
        else $error("answer not released");

    property p_ans_cause;
        $rose(bp_ack || bp_berr) |-> bp_req;
    endproperty
    a_ans_cause: assert property (p_ans_cause)
        else $error("answer without request");

    property p_lk_quiet;
        !lk_req [*4] |-> !(lk_ack || lk_berr);
    endproperty
    a_lk_quiet: assert property (p_lk_quiet)
        else $error("link answer without request");

    property p_rel_pulse;
        rel_valid |=> !rel_valid;
    endproperty
    a_rel_pulse: assert property (p_rel_pulse)
        else $error("release longer than one cycle");

    property p_lk_irq;
        $past(nrst) |-> lk_irq == $past(ctrl_bit3 && irq_req);
    endproperty
    a_lk_irq: assert property (p_lk_irq)
        else $error("link irq wrong");

    property p_token_pass;
        $rose(token_out) |-> $past(chain_pos) inside {EBR_CH_FIRST, EBR_CH_MID};
    endproperty
    a_token_pass: assert property (p_token_pass)
        else $error("token passed by end board");

    c_ack: cover property (bp_ack);
    c_berr: cover property (bp_berr);
    c_rel: cover property (rel_valid);
    c_tok: cover property ($rose(token_out));
endmodule // ebr_readout_checker

bind ebr_readout ebr_readout_checker u_chk (
    .ref_clk, .nrst, .bp_req, .bp_ack, .bp_berr, .lk_req, .lk_ack,
    .lk_berr, .chain_pos, .token_out, .rel_valid, .ctrl_bit3, .irq_req,
    .lk_irq
);

/* File: verif/tb_ebr_readout.sv */
// self-checking bench for the readout engine
// assumes: memory stand-in answers one clock after a read
`timescale 1ns/10ps
`include "ebr_regs.svh"
module tb_ebr_readout;
    import ebr_pkg::*;
    localparam logic [31:0] BA = 32'h1000_0000;
    localparam logic [31:0] CB = 32'h2000_0000;
    localparam logic [5:0] AS = `EBR_AM_A32_S;
    localparam logic [5:0] AB = `EBR_AM_A32_BLT;
    localparam logic [5:0] AM64 = `EBR_AM_A32_MBLT;
    logic ref_clk = 1'b0;
    logic nrst = 1'b0;
    logic cyc [2] = '{1'b0, 1'b0};
    logic req [2] = '{1'b0, 1'b0};
    logic wr [2] = '{1'b0, 1'b0};
    logic dw [2] = '{1'b0, 1'b0};
    logic [31:0] adr [2] = '{32'h0, 32'h0};
    logic [5:0] am [2] = '{6'h0, 6'h0};
    logic [63:0] dat [2];
    logic ack [2];
    logic be [2];
    ebr_chain_t chain_pos = EBR_CH_OFF;
    logic token_in = 1'b0;
    logic [7:0] blt_events = 8'h00;
    logic berr_en = 1'b0;
    logic pad = 1'b0;
    logic free_wr = 1'b0;
    logic [11:0] free_cnt = 12'h000;
    logic rnd_req = 1'b0;
    logic [11:0] rnd_page = 12'h000;
    logic [11:0] rnd_off = 12'h000;
    logic [9:0] rnd_size = 10'h000;
    logic ctrl_bit3 = 1'b0;
    logic irq_req = 1'b0;
    logic token_out, mem_rd, rel_valid, rnd_active, lk_irq;
    logic [23:0] mem_addr;
    logic [31:0] mem_data;
    logic [11:0] rel_cnt;
    logic [11:0] last_cnt = 12'h000;
    int n_fail = 0;
    int compares = 0;
    int n_rel = 0;
    realtime t_be [2] = '{0.0, 0.0};
    realtime t_fork = 0.0;
    // address beside expected word: page 0 whole, then next header
    logic [63:0] rw [9] = '{64'h10000000_c0000000, 64'h10000ffc_c0000001,
        64'h10000004_c0000002, 64'h10000800_c0000003, 64'h10000010_c0000004,
        64'h10000ffc_c0000005, 64'h10000ab8_c0000006, 64'h10000008_c0000007,
        64'h10000000_c0001000};

    ebr_readout #(.BS_W(10), .NEV_W(8)) dut (
        .ref_clk, .nrst,
        .bp_cyc(cyc[0]), .bp_req(req[0]), .bp_addr(adr[0]), .bp_am(am[0]),
        .bp_wr(wr[0]), .bp_dw64(dw[0]), .bp_ack(ack[0]), .bp_berr(be[0]),
        .bp_data(dat[0]),
        .lk_cyc(cyc[1]), .lk_req(req[1]), .lk_addr(adr[1]), .lk_am(am[1]),
        .lk_wr(wr[1]), .lk_dw64(dw[1]), .lk_ack(ack[1]), .lk_berr(be[1]),
        .lk_data(dat[1]),
        .base_addr(BA), .chain_base(CB), .chain_pos, .token_in, .token_out,
        .blt_events, .berr_en, .pad_to_even_word_count(pad),
        .block_size(10'h002), .ev_wr_page(12'h003), .mem_rd, .mem_addr,
        .mem_data, .rel_valid, .rel_cnt, .free_wr, .free_cnt, .rnd_req,
        .rnd_page, .rnd_off, .rnd_size, .rnd_active, .ctrl_bit3, .irq_req,
        .lk_irq
    );
    ebr_mem_model u_mem (.ref_clk, .mem_rd, .mem_addr, .mem_data);

    always #2 ref_clk = ~ref_clk;

    always @(posedge ref_clk) begin
        if (rel_valid === 1'b1) begin
            n_rel++;
            last_cnt = rel_cnt;
        end
        for (int q = 0; q < 2; q++)
            if (be[q] === 1'b1 && t_be[q] < t_fork)
                t_be[q] = $realtime;
    end

    function automatic logic [31:0] wd(input int pg, input int w);
        return {8'hc0, pg[11:0], w[11:0]};
    endfunction

    task automatic chk_d(input logic [63:0] g, input logic [63:0] e);
        compares++;
        if (g !== e) begin
            n_fail++;
            $display("FAIL t=%0t got %h exp %h", $time, g, e);
        end
    endtask

    task automatic chk_f(input logic g, input logic e);
        compares++;
        if (g !== e) begin
            n_fail++;
            $display("FAIL t=%0t got %h exp %h", $time, g, e);
        end
    endtask

    // one beat on path p; f = {write, 64-bit, end of cycle}
    task automatic bt(input int p, input logic [31:0] a, input logic [5:0] m,
        input logic [2:0] f, input logic [1:0] xr, input logic [63:0] xd);
        int i;
        @(posedge ref_clk);
        cyc[p] <= 1'b1;
        req[p] <= 1'b1;
        adr[p] <= a;
        am[p] <= m;
        wr[p] <= f[2];
        dw[p] <= f[1];
        @(posedge ref_clk);
        for (i = 0; i < 24 && ack[p] !== 1'b1 && be[p] !== 1'b1; i++)
            @(posedge ref_clk);
        chk_f(be[p], xr[1]);
        chk_f(ack[p], xr[0]);
        if (xr[0])
            chk_d(f[1] ? dat[p] : {32'h0, dat[p][31:0]}, xd);
        req[p] <= 1'b0;
        if (f[0])
            cyc[p] <= 1'b0;
        for (i = 0; i < 8 && (ack[p] === 1'b1 || be[p] === 1'b1); i++)
            @(posedge ref_clk);
    endtask

    task automatic wrap_up();
        if (n_fail == 0 && compares > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask

    // whole run needs well under two thousand ns; cut off well past that
    initial begin
        #20000;
        n_fail++;
        wrap_up();
    end

    initial begin
        repeat (5) @(posedge ref_clk);
        nrst <= 1'b1;
        @(posedge ref_clk);
        chk_f(token_out, 1'b0);
        chk_f(rel_valid, 1'b0);
        foreach (rw[k])
            bt(0, rw[k][63:32], AS, 3'b001, 2'b01, rw[k][31:0]);
        chk_f(n_rel == 1 && last_cnt === 12'h001, 1'b1);
        pad <= 1'b1;
        blt_events <= 8'h01;
        for (int w = 1; w < 8; w++)
            bt(0, BA, AB, 3'b000, 2'b01, wd(1, w));
        bt(0, BA, AB, 3'b000, 2'b01, `EBR_DUMMY);
        bt(0, BA, AB, 3'b001, 2'b01, `EBR_FILLER);
        pad <= 1'b0;
        berr_en <= 1'b1;
        for (int w = 0; w < 8; w += 2)
            bt(0, BA, AM64, 3'b010, 2'b01, {wd(2, w + 1), wd(2, w)});
        bt(0, BA, AM64, 3'b011, 2'b10, 64'h0);
        chk_f(n_rel == 3, 1'b1);
        bt(0, BA, AS, 3'b011, 2'b10, 64'h0);
        bt(0, BA, AS, 3'b101, 2'b10, 64'h0);
        bt(1, BA, AB, 3'b101, 2'b10, 64'h0);
        bt(0, 32'h3000_0000, AS, 3'b001, 2'b00, 64'h0);
        t_fork = $realtime;
        fork
            bt(0, BA, 6'h2f, 3'b001, 2'b10, 64'h0);
            bt(1, BA, 6'h2f, 3'b001, 2'b10, 64'h0);
        join
        chk_f(t_be[0] > t_fork && t_be[0] < t_be[1], 1'b1);
        ctrl_bit3 <= 1'b1;
        irq_req <= 1'b1;
        repeat (2) @(posedge ref_clk);
        chk_f(lk_irq, 1'b1);
        ctrl_bit3 <= 1'b0;
        repeat (2) @(posedge ref_clk);
        chk_f(lk_irq, 1'b0);
        chain_pos <= EBR_CH_LAST;
        bt(0, CB, AB, 3'b001, 2'b00, 64'h0);
        token_in <= 1'b1;
        bt(0, CB, AB, 3'b001, 2'b10, 64'h0);
        chain_pos <= EBR_CH_FIRST;
        bt(0, CB, AB, 3'b001, 2'b00, 64'h0);
        chk_f(token_out, 1'b1);
        repeat (3) @(posedge ref_clk);
        chk_f(token_out, 1'b0);
        chain_pos <= EBR_CH_OFF;
        rnd_req <= 1'b1;
        rnd_page <= 12'h001;
        rnd_off <= 12'h002;
        rnd_size <= 10'h002;
        @(posedge ref_clk);
        rnd_req <= 1'b0;
        @(posedge ref_clk);
        chk_f(rnd_active, 1'b1);
        bt(0, BA, AS, 3'b001, 2'b01, {`EBR_HDR_TAG, 28'h6});
        for (int w = 1; w < 4; w++)
            bt(0, BA, AS, 3'b001, 2'b01, wd(1, w));
        for (int w = 6; w < 8; w++)
            bt(0, BA, AS, 3'b001, 2'b01, wd(1, w));
        bt(0, BA, AS, 3'b001, 2'b10, 64'h0);
        chk_f(n_rel == 3, 1'b1);
        free_wr <= 1'b1;
        free_cnt <= 12'h002;
        @(posedge ref_clk);
        free_wr <= 1'b0;
        repeat (3) @(posedge ref_clk);
        chk_d({52'h0, last_cnt}, 64'h2);
        chk_f(rnd_active, 1'b0);
        wrap_up();
    end
endmodule // tb_ebr_readout
